// File: src/rhc_device.sv
// Operation
// - Capture serial input on clock rising edges.
// - Select low enables port, frames each access.
// - Select held low gives auto-increment bursts.
// - Serial input carries command and write data.
// - Register contents shifted out on reads.
// - Enabled pending event drives interrupt low.
// - Host reads two status registers for cause.
// - Host holds shutdown low outside shutdown.
// - Shutdown high clears all register contents.
// - Each pin has its own configuration register.
// - Pins offer clock, status and switch functions.
`timescale 1ns/100ps
module rhc_device (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        srst,
    // Link to the controller.
    rhc_link_if.dev          link,
    // Interrupt event sources, one pulse or level per status bit.
    input  wire logic [15:0] event_in,
    // Internal flags offered on the pins.
    input  wire logic        por_flag,
    input  wire logic        wake_flag,
    input  wire logic        low_batt_flag,
    input  wire logic        fifo_flag,
    input  wire logic        tx_active,
    input  wire logic        antenna_select
);

    typedef struct packed {
        logic        sclk_prev;
        logic        in_cmd;
        logic        is_wr;
        logic [2:0]  bit_cnt;
        logic [6:0]  shift_in;
        logic [6:0]  addr;
        logic [7:0]  shift_out;
        logic [15:0] stat;
        logic [15:0] enable;
        logic [7:0]  cfg0;
        logic [7:0]  cfg1;
        logic [7:0]  cfg2;
        logic        clk_div;
        logic        ser_out;
        logic        irq_n;
        logic [2:0]  pin_out;
        logic [2:0]  pin_oe;
    } rhc_dev_t;

    localparam rhc_dev_t RST = '{
        sclk_prev: 1'h0,
        in_cmd:    1'h1,
        is_wr:     1'h0,
        bit_cnt:   3'h0,
        shift_in:  7'h00,
        addr:      7'h00,
        shift_out: rhc_pkg::RST_BYTE,
        stat:      rhc_pkg::RST_WORD,
        enable:    rhc_pkg::RST_WORD,
        cfg0:      rhc_pkg::RST_BYTE,
        cfg1:      rhc_pkg::RST_BYTE,
        cfg2:      rhc_pkg::RST_BYTE,
        clk_div:   1'h0,
        ser_out:   1'h0,
        irq_n:     1'h1,
        pin_out:   3'h0,
        pin_oe:    3'h0
    };

    rhc_dev_t s;
    rhc_dev_t next_s;

    // Returns the byte readable at a register address; unmapped reads zero.
    function automatic logic [7:0] reg_read(input logic [6:0] a, input rhc_dev_t v);
        logic [7:0] r;
        r = rhc_pkg::RST_BYTE;
        case (a)
            rhc_pkg::REG_STAT1: r = v.stat[7:0];
            rhc_pkg::REG_STAT2: r = v.stat[15:8];
            rhc_pkg::REG_EN1:   r = v.enable[7:0];
            rhc_pkg::REG_EN2:   r = v.enable[15:8];
            rhc_pkg::REG_PIN0:  r = v.cfg0;
            rhc_pkg::REG_PIN1:  r = v.cfg1;
            rhc_pkg::REG_PIN2:  r = v.cfg2;
            default:            r = rhc_pkg::RST_BYTE;
        endcase
        return r;
    endfunction : reg_read

    // Returns the status bits that a read of this address hands to the host.
    function automatic logic [15:0] read_clear(input logic [6:0] a, input rhc_dev_t v);
        logic [15:0] c;
        c = rhc_pkg::RST_WORD;
        case (a)
            rhc_pkg::REG_STAT1: c = {8'h00, v.stat[7:0]};
            rhc_pkg::REG_STAT2: c = {v.stat[15:8], 8'h00};
            default:            c = rhc_pkg::RST_WORD;
        endcase
        return c;
    endfunction : read_clear

    // Maps a pin configuration onto {enable, level}; unknown codes float the pin.
    function automatic logic [1:0] pin_fn(input logic [7:0] cfg, input rhc_dev_t v);
        logic [1:0] r;
        r = 2'h0;
        case (cfg[rhc_pkg::FN_W-1:0])
            rhc_pkg::FN_POR:      r = {1'h1, por_flag};
            rhc_pkg::FN_WAKE:     r = {1'h1, wake_flag};
            rhc_pkg::FN_LOWBAT:   r = {1'h1, low_batt_flag};
            rhc_pkg::FN_FIFO:     r = {1'h1, fifo_flag};
            rhc_pkg::FN_CLK:      r = {1'h1, v.clk_div};
            rhc_pkg::FN_TXRX:     r = {1'h1, tx_active};
            rhc_pkg::FN_TXRX_INV: r = {1'h1, ~tx_active};
            rhc_pkg::FN_ANT:      r = {1'h1, antenna_select};
            default:              r = 2'h0;
        endcase
        return r;
    endfunction : pin_fn

    // Serial port, event capture and pin functions.
    always_comb begin
        logic       rise;
        logic       fall;
        logic [7:0] rx_byte;
        logic [6:0] rd_addr;
        logic [15:0] clr;
        logic [1:0] p0;
        logic [1:0] p1;
        logic [1:0] p2;
        rise    = 1'h0;
        fall    = 1'h0;
        rx_byte = rhc_pkg::RST_BYTE;
        rd_addr = 7'h00;
        clr     = rhc_pkg::RST_WORD;
        p0      = 2'h0;
        p1      = 2'h0;
        p2      = 2'h0;
        next_s  = s;
        next_s.sclk_prev = link.sclk;
        rise    = link.sclk & ~s.sclk_prev;
        fall    = ~link.sclk & s.sclk_prev;
        rx_byte = {s.shift_in, link.serial_in_pin};
        if (link.serial_select_n) begin
            next_s.in_cmd    = 1'h1;
            next_s.bit_cnt   = 3'h0;
            next_s.shift_out = rhc_pkg::RST_BYTE;
        end else if (rise) begin
            next_s.shift_in = rx_byte[6:0];
            next_s.bit_cnt  = s.bit_cnt + 3'h1;
            if (s.bit_cnt == rhc_pkg::BIT_LAST) begin
                if (s.in_cmd) begin
                    next_s.in_cmd = 1'h0;
                    next_s.is_wr  = rx_byte[rhc_pkg::CMD_RW_POS];
                    next_s.addr   = rx_byte[6:0];
                    rd_addr       = rx_byte[6:0];
                end else begin
                    next_s.addr = s.addr + 7'h01;
                    rd_addr     = s.addr + 7'h01;
                    if (s.is_wr) begin
                        case (s.addr)
                            rhc_pkg::REG_EN1:  next_s.enable[7:0]  = rx_byte;
                            rhc_pkg::REG_EN2:  next_s.enable[15:8] = rx_byte;
                            rhc_pkg::REG_PIN0: next_s.cfg0 = rx_byte;
                            rhc_pkg::REG_PIN1: next_s.cfg1 = rx_byte;
                            rhc_pkg::REG_PIN2: next_s.cfg2 = rx_byte;
                            default:           next_s.cfg0 = next_s.cfg0;
                        endcase
                    end
                end
                if (!(s.in_cmd ? rx_byte[rhc_pkg::CMD_RW_POS] : s.is_wr)) begin
                    next_s.shift_out = reg_read(rd_addr, s);
                    clr = read_clear(rd_addr, s);
                end
            end
        end else if (fall) begin
            next_s.ser_out   = s.shift_out[7];
            next_s.shift_out = {s.shift_out[6:0], 1'h0};
        end
        next_s.stat  = (s.stat & ~clr) | (event_in & s.enable);
        next_s.irq_n = ~(|next_s.stat);
        next_s.clk_div = ~s.clk_div;
        p0 = pin_fn(s.cfg0, s);
        p1 = pin_fn(s.cfg1, s);
        p2 = pin_fn(s.cfg2, s);
        next_s.pin_oe  = {p2[1], p1[1], p0[1]};
        next_s.pin_out = {p2[0], p1[0], p0[0]};
    end

    // State register; shutdown wipes every register like a reset.
    always_ff @(posedge mclk) begin
        if (srst || link.shutdown_pin) begin
            s <= RST;
        end else begin
            s <= next_s;
        end
    end

    // Pin drivers come straight from the state register.
    assign link.serial_out_pin     = s.ser_out;
    assign link.host_interrupt_low = s.irq_n;
    assign link.pin_out            = s.pin_out;
    assign link.pin_oe             = s.pin_oe;

endmodule : rhc_device

// File: src/rhc_pkg.sv
package rhc_pkg;
    // Serial frame layout and device register map.
    localparam int          ADDR_W       = 7;
    localparam int          BYTE_W       = 8;
    localparam int          CMD_RW_POS   = 7;
    localparam logic [2:0]  BIT_LAST     = 3'h7;
    localparam logic [6:0]  REG_STAT1    = 7'h03;
    localparam logic [6:0]  REG_STAT2    = 7'h04;
    localparam logic [6:0]  REG_EN1      = 7'h05;
    localparam logic [6:0]  REG_EN2      = 7'h06;
    localparam logic [6:0]  REG_PIN0     = 7'h0B;
    localparam logic [6:0]  REG_PIN1     = 7'h0C;
    localparam logic [6:0]  REG_PIN2     = 7'h0D;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam int          NUM_PINS     = 3;

    // Pin function codes held in the low bits of each pin configuration.
    localparam int          FN_W         = 5;
    localparam logic [4:0]  FN_POR       = 5'h00;
    localparam logic [4:0]  FN_WAKE      = 5'h01;
    localparam logic [4:0]  FN_LOWBAT    = 5'h02;
    localparam logic [4:0]  FN_FIFO      = 5'h03;
    localparam logic [4:0]  FN_CLK       = 5'h04;
    localparam logic [4:0]  FN_TXRX      = 5'h05;
    localparam logic [4:0]  FN_TXRX_INV  = 5'h06;
    localparam logic [4:0]  FN_ANT       = 5'h07;

    // Controller register map on the system bus.
    localparam logic [7:0]  H_CTRL       = 8'h00;
    localparam logic [7:0]  H_WDATA      = 8'h04;
    localparam logic [7:0]  H_RDATA      = 8'h08;
    localparam logic [7:0]  H_STAT       = 8'h0C;
    localparam logic [7:0]  H_ISTAT      = 8'h10;
    localparam logic [7:0]  H_IMASK      = 8'h14;
    localparam logic [7:0]  H_SHUT       = 8'h18;
    localparam int          CTRL_START   = 0;
    localparam int          CTRL_WRITE   = 1;
    localparam int          CTRL_ADDR_LO = 8;
    localparam int          CTRL_CNT_LO  = 16;
    localparam int          INT_DONE     = 0;
    localparam int          INT_DEV      = 1;
    localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
    localparam logic        HRESP_OKAY   = 1'h0;

    // Serial clock half period.
    localparam int          CLK_NS       = 5;
    localparam int          SCLK_HALF_NS = 20;
    localparam int          SCLK_HALF    = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;

    // Controller sequencer states.
    typedef enum logic [2:0] {
        RHC_IDLE  = 3'h0,
        RHC_SETUP = 3'h1,
        RHC_LOW   = 3'h3,
        RHC_HIGH  = 3'h2,
        RHC_HOLD  = 3'h6
    } rhc_state_t;
endpackage : rhc_pkg

// File: src/rhc_link_if.sv
`timescale 1ns/100ps
interface rhc_link_if;
    // Serial port, interrupt, shutdown and pin lines.
    logic       sclk;
    logic       serial_in_pin;
    logic       serial_select_n;
    logic       serial_out_pin;
    logic       host_interrupt_low;
    logic       shutdown_pin;
    logic [2:0] pin_out;
    logic [2:0] pin_oe;

    modport dev (
        input  sclk,
        input  serial_in_pin,
        input  serial_select_n,
        input  shutdown_pin,
        output serial_out_pin,
        output host_interrupt_low,
        output pin_out,
        output pin_oe
    );

    modport host (
        output sclk,
        output serial_in_pin,
        output serial_select_n,
        output shutdown_pin,
        input  serial_out_pin,
        input  host_interrupt_low,
        input  pin_out,
        input  pin_oe
    );
endinterface : rhc_link_if

// File: src/rhc_host.sv
`timescale 1ns/100ps
module rhc_host #(
    parameter int HALF = rhc_pkg::SCLK_HALF
) (
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        srst,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Interrupt to the system.
    output logic             intr,
    // Link to the device.
    rhc_link_if.host         link
);

    typedef struct packed {
        logic       rdy;
        logic       wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata_bus;
        rhc_pkg::rhc_state_t st;
        logic [7:0] cnt;
        logic [5:0] bitpos;
        logic [5:0] last_bit;
        logic       is_wr;
        logic [7:0] cmd;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [1:0] int_stat;
        logic [1:0] int_mask;
        logic       shut;
        logic       sclk;
        logic       ser_in;
        logic       sel_n;
        logic       intr;
    } rhc_host_t;

    localparam rhc_host_t RST = '{
        st: rhc_pkg::RHC_IDLE, sel_n: 1'h1, default: '0
    };

    rhc_host_t s;
    rhc_host_t next_s;

    // Bus read decode of the controller registers.
    function automatic logic [31:0] bus_read(input logic [7:0] a, input rhc_host_t v);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            rhc_pkg::H_WDATA: r = v.wdata;
            rhc_pkg::H_RDATA: r = v.rdata;
            rhc_pkg::H_STAT:  r = {30'h0, ~link.host_interrupt_low, v.st != rhc_pkg::RHC_IDLE};
            rhc_pkg::H_ISTAT: r = {30'h0, v.int_stat};
            rhc_pkg::H_IMASK: r = {30'h0, v.int_mask};
            rhc_pkg::H_SHUT:  r = {31'h0, v.shut};
            default:          r = 32'h0;
        endcase
        return r;
    endfunction : bus_read

    // Bit sent at a frame position: command byte first, then data bytes low first.
    function automatic logic tx_bit(input logic [5:0] p, input rhc_host_t v);
        logic [39:0] frame;
        frame = {v.wdata, v.cmd};
        return frame[{p[5:3], ~p[2:0]}];
    endfunction : tx_bit

    // Bus slave, serial sequencer and interrupt logic.
    always_comb begin
        logic [1:0] clr;
        logic [1:0] ev;
        logic       tdone;
        clr    = 2'h0;
        ev     = 2'h0;
        tdone  = 1'h0;
        next_s = s;
        next_s.rdy = 1'h1;
        tdone  = (s.cnt == 8'(HALF - 1));
        next_s.cnt = tdone ? 8'h00 : s.cnt + 8'h01;
        case (s.st)
            rhc_pkg::RHC_IDLE: begin
                next_s.cnt = 8'h00;
            end
            rhc_pkg::RHC_SETUP: begin
                if (tdone) begin
                    next_s.st  = rhc_pkg::RHC_LOW;
                    next_s.ser_in = tx_bit(s.bitpos, s);
                end
            end
            rhc_pkg::RHC_LOW: begin
                if (tdone) begin
                    next_s.st   = rhc_pkg::RHC_HIGH;
                    next_s.sclk = 1'h1;
                    if (!s.is_wr && s.bitpos[5:3] != 3'h0) begin
                        next_s.rdata[{s.bitpos[4:3] - 2'h1, ~s.bitpos[2:0]}] = link.serial_out_pin;
                    end
                end
            end
            rhc_pkg::RHC_HIGH: begin
                if (tdone && s.bitpos == s.last_bit) begin
                    next_s.st = rhc_pkg::RHC_HOLD;
                end else if (tdone) begin
                    next_s.st     = rhc_pkg::RHC_LOW;
                    next_s.sclk   = 1'h0;
                    next_s.bitpos = s.bitpos + 6'h01;
                    next_s.ser_in = tx_bit(s.bitpos + 6'h01, s);
                end
            end
            rhc_pkg::RHC_HOLD: begin
                if (tdone) begin
                    next_s.st    = rhc_pkg::RHC_IDLE;
                    next_s.sclk  = 1'h0;
                    next_s.sel_n = 1'h1;
                    ev[rhc_pkg::INT_DONE] = 1'h1;
                end
            end
            default: begin
                next_s.st = rhc_pkg::RHC_IDLE;
            end
        endcase
        // Data phase of a bus write.
        if (s.wr_pend) begin
            case (s.wr_addr)
                rhc_pkg::H_CTRL: begin
                    if (hwdata[rhc_pkg::CTRL_START] && s.st == rhc_pkg::RHC_IDLE) begin
                        next_s.st       = rhc_pkg::RHC_SETUP;
                        next_s.sel_n    = 1'h0;
                        next_s.cnt      = 8'h00;
                        next_s.bitpos   = 6'h00;
                        next_s.is_wr    = hwdata[rhc_pkg::CTRL_WRITE];
                        next_s.cmd      = {hwdata[rhc_pkg::CTRL_WRITE], hwdata[rhc_pkg::CTRL_ADDR_LO +: 7]};
                        next_s.last_bit = {{1'h0, hwdata[rhc_pkg::CTRL_CNT_LO +: 2]} + 3'h1, 3'h7};
                    end
                end
                rhc_pkg::H_WDATA: next_s.wdata    = hwdata;
                rhc_pkg::H_ISTAT: clr             = hwdata[1:0];
                rhc_pkg::H_IMASK: next_s.int_mask = hwdata[1:0];
                rhc_pkg::H_SHUT:  next_s.shut     = hwdata[0];
                default:          next_s.shut     = next_s.shut;
            endcase
        end
        ev[rhc_pkg::INT_DEV] = ~link.host_interrupt_low;
        next_s.int_stat = (s.int_stat & ~clr) | ev;
        next_s.intr     = |(next_s.int_stat & next_s.int_mask);
        // Address phase of a bus transfer.
        next_s.wr_pend = hsel && hready && htrans == rhc_pkg::HTRANS_NSEQ && hwrite;
        next_s.wr_addr = haddr[7:0];
        if (hsel && hready && htrans == rhc_pkg::HTRANS_NSEQ && !hwrite) begin
            next_s.rdata_bus = bus_read(haddr[7:0], next_s);
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (srst) begin
            s <= RST;
        end else begin
            s <= next_s;
        end
    end

    // Outputs from the state register; hresp is tied to OKAY.
    assign hreadyout            = s.rdy;
    assign hresp                = rhc_pkg::HRESP_OKAY;
    assign hrdata               = s.rdata_bus;
    assign intr                 = s.intr;
    assign link.sclk            = s.sclk;
    assign link.serial_in_pin   = s.ser_in;
    assign link.serial_select_n = s.sel_n;
    assign link.shutdown_pin    = s.shut;

endmodule : rhc_host

// File: testbench/rhc_checker.sv
`timescale 1ns/100ps
module rhc_checker (
    // Clock and reset.
    input wire logic       mclk,
    input wire logic       srst,
    // Link lines.
    input wire logic       sclk,
    input wire logic       serial_in_pin,
    input wire logic       serial_select_n,
    input wire logic       serial_out_pin,
    input wire logic       host_interrupt_low,
    input wire logic       shutdown_pin,
    input wire logic [2:0] pin_oe
);
    logic       sclk_q;
    logic [7:0] rises;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    // Counts serial clock rises inside one selected frame, so the frame can be judged when it closes.
    always_ff @(posedge mclk) begin
        sclk_q <= sclk;
        if (srst || serial_select_n) begin
            rises <= 8'h00;
        end else if (sclk && !sclk_q) begin
            rises <= rises + 8'h01;
        end
    end

    // Serial frame shape, clock phases and the held lines.
    a_idle_clock_low: assert property (serial_select_n |-> !sclk)
        else $error("serial clock high while deselected");
    a_deselect_after_high: assert property ($rose(serial_select_n) |-> $past(sclk))
        else $error("frame closed without a final clock high phase");
    a_setup_before_clock: assert property ($fell(serial_select_n) |-> !sclk [*4])
        else $error("serial clock rose too soon after select");
    a_clock_high_time: assert property ($rose(sclk) |-> sclk [*3])
        else $error("serial clock high phase too short");
    a_input_held_high: assert property (sclk && $past(sclk) |-> $stable(serial_in_pin))
        else $error("serial input moved while clock high");
    a_output_held_high: assert property (sclk && $past(sclk) && !shutdown_pin && !$past(shutdown_pin)
        |-> $stable(serial_out_pin))
        else $error("serial output moved while clock high");
    a_burst_byte_count: assert property ($rose(serial_select_n)
        |-> rises[2:0] == 3'h0 && rises >= 8'h10 && rises <= 8'h28)
        else $error("frame was not whole bytes of a legal burst");
    // Shutdown and interrupt release.
    a_shutdown_clears: assert property (shutdown_pin |=> host_interrupt_low && pin_oe == 3'h0 && !serial_out_pin)
        else $error("device outputs not cleared by shutdown");
    a_irq_release_cause: assert property ($rose(host_interrupt_low) |-> !serial_select_n || $past(shutdown_pin))
        else $error("interrupt released without a status read");
endmodule : rhc_checker

// File: testbench/radio_host_control_pins_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module radio_host_control_pins_tb_top;
    logic        mclk;
    logic        srst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        intr;
    logic [15:0] event_in;
    logic [5:0]  flags;
    logic [31:0] rd;
    logic [15:0] en;
    logic [15:0] ev;
    logic [23:0] cfg;
    logic [4:0]  fn;
    logic        last;
    int          p;
    int          mismatches;
    int          compares;
    logic [7:0]  rst_addr [7] = '{rhc_pkg::H_CTRL, rhc_pkg::H_ISTAT, rhc_pkg::H_IMASK, rhc_pkg::H_SHUT, 8'h1C,
                                  rhc_pkg::H_WDATA, rhc_pkg::H_RDATA};

    rhc_link_if link ();

    // Both ends face each other across the link; the checker watches the link.
    rhc_host #(.HALF(4)) u_rhc_host (.mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .intr(intr), .link(link));
    rhc_device u_rhc_device (.mclk(mclk), .srst(srst), .link(link), .event_in(event_in), .por_flag(flags[0]),
        .wake_flag(flags[1]), .low_batt_flag(flags[2]), .fifo_flag(flags[3]), .tx_active(flags[4]),
        .antenna_select(flags[5]));
    rhc_checker u_rhc_checker (.mclk(mclk), .srst(srst), .sclk(link.sclk), .serial_in_pin(link.serial_in_pin),
        .serial_select_n(link.serial_select_n), .serial_out_pin(link.serial_out_pin),
        .host_interrupt_low(link.host_interrupt_low), .shutdown_pin(link.shutdown_pin), .pin_oe(link.pin_oe));

    // Free-running system clock.
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    // Expected pin level for a function code and the flag inputs.
    function automatic logic pin_exp(input logic [4:0] c, input logic [5:0] fl);
        case (c)
            rhc_pkg::FN_TXRX:     return fl[4];
            rhc_pkg::FN_TXRX_INV: return ~fl[4];
            rhc_pkg::FN_ANT:      return fl[5];
            default:              return fl[c];
        endcase
    endfunction : pin_exp

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // Waits a bounded time for hready high at a rising edge.
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            complete_run();
        end
    endtask : wait_ready

    // One single-word transfer: address phase, then data phase.
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= rhc_pkg::HTRANS_NSEQ;
        haddr <= {24'h000000, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        `CHK(hresp, rhc_pkg::HRESP_OKAY)
    endtask : ahb

    // One serial frame of a command byte and n data bytes, then a bounded wait for idle and a fetch of the received bytes.
    task automatic spi(input logic w, input logic [6:0] a, input int n, input logic [31:0] d);
        int k;
        if (w) ahb(1'b1, rhc_pkg::H_WDATA, d);
        ahb(1'b1, rhc_pkg::H_CTRL, {14'h0000, 2'(n - 1), 1'b0, a, 6'h00, w, 1'b1});
        k = 0;
        do begin
            ahb(1'b0, rhc_pkg::H_STAT, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 400);
        if (rd[0] !== 1'b0) begin
            mismatches++;
            complete_run();
        end
        ahb(1'b0, rhc_pkg::H_RDATA, 32'h0);
    endtask : spi

    // Main sequence.
    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        event_in = 16'h0000;
        flags = 6'h00;
        mismatches = 0;
        compares = 0;
        rd = $urandom(14620);
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        // Idle state after reset, unmapped address included.
        for (int i = 0; i < 7; i++) begin
            ahb(1'b0, rst_addr[i], 32'h0);
            `CHK(rd, 32'h00000000)
        end
        `CHK(link.shutdown_pin, 1'b0)
        `CHK(link.host_interrupt_low, 1'b1)
        // Burst write of all pin configurations, burst read starting one below them.
        cfg = 24'($urandom);
        spi(1'b1, rhc_pkg::REG_PIN0, 3, {8'h00, cfg});
        spi(1'b0, 7'h0A, 4, 32'h0);
        `CHK(rd, {cfg, 8'h00})
        // Every pin function on a random pin with random flags, then one unused code.
        for (int f = 0; f < 9; f++) begin
            p = $urandom_range(2, 0);
            fn = 5'(f);
            spi(1'b1, rhc_pkg::REG_PIN0 + 7'(p), 1, {27'h0, fn});
            flags <= 6'($urandom);
            repeat (3) @(negedge mclk);
            `CHK(link.pin_oe[p], 1'(f < 8))
            if (f != 4 && f < 8) `CHK(link.pin_out[p], pin_exp(fn, flags))
            if (f == 4) begin
                last = link.pin_out[p];
                @(negedge mclk);
                `CHK(link.pin_out[p], ~last)
            end
        end
        // Events outside the enables are ignored; enabled ones pull the line low.
        en = 16'($urandom) | 16'h8001;
        ev = 16'($urandom) | 16'h8001;
        spi(1'b1, rhc_pkg::REG_EN1, 2, {16'h0000, en});
        ahb(1'b1, rhc_pkg::H_ISTAT, 32'h3);
        event_in <= ~en;
        @(posedge mclk);
        event_in <= 16'h0000;
        repeat (3) @(negedge mclk);
        `CHK(link.host_interrupt_low, 1'b1)
        @(posedge mclk);
        event_in <= ev;
        @(posedge mclk);
        event_in <= 16'h0000;
        repeat (3) @(negedge mclk);
        `CHK(link.host_interrupt_low, 1'b0)
        ahb(1'b0, rhc_pkg::H_STAT, 32'h0);
        `CHK(rd[1], 1'b1)
        ahb(1'b1, rhc_pkg::H_IMASK, 32'h2);
        repeat (2) @(negedge mclk);
        `CHK(intr, 1'b1)
        ahb(1'b1, rhc_pkg::H_IMASK, 32'h0);
        repeat (2) @(negedge mclk);
        `CHK(intr, 1'b0)
        // Status read reports the cause and releases the line.
        spi(1'b0, rhc_pkg::REG_STAT1, 2, 32'h0);
        `CHK(rd[15:0], ev & en)
        repeat (3) @(negedge mclk);
        `CHK(link.host_interrupt_low, 1'b1)
        // Status register 1 refuses a write and both status registers stay clear.
        spi(1'b1, rhc_pkg::REG_STAT1, 1, 32'hFF);
        spi(1'b0, rhc_pkg::REG_STAT1, 2, 32'h0);
        `CHK(rd[15:0], 16'h0000)
        ahb(1'b1, rhc_pkg::H_ISTAT, 32'h3);
        ahb(1'b0, rhc_pkg::H_ISTAT, 32'h0);
        `CHK(rd, 32'h00000000)
        // Shutdown with an event pending wipes every device register.
        @(posedge mclk);
        event_in <= ev;
        @(posedge mclk);
        event_in <= 16'h0000;
        ahb(1'b1, rhc_pkg::H_SHUT, 32'h1);
        repeat (2) @(negedge mclk);
        `CHK(link.shutdown_pin, 1'b1)
        `CHK(link.host_interrupt_low, 1'b1)
        ahb(1'b1, rhc_pkg::H_SHUT, 32'h0);
        spi(1'b0, rhc_pkg::REG_PIN0, 3, 32'h0);
        `CHK(rd[23:0], 24'h000000)
        spi(1'b0, rhc_pkg::REG_EN1, 2, 32'h0);
        `CHK(rd[15:0], 16'h0000)
        complete_run();
    end
endmodule : radio_host_control_pins_tb_top
